/* File: tbi_decoder.sv */
/*
 * Index-mode decoder for one 128-bit compressed 3D texture block, with an
 * APB slave for block load, footprint, texel request and results.
 * Assumes a zero-wait APB master on pclk and one texel request at a time.
 */
`timescale 1ns/1ps

// How it works
// - 3D index-mode layout gives grid dimensions
// - dual-plane flag selects one or two planes
// - dual plane allows at most three partitions
// - grid larger than footprint gives error colour
// - penultimate row void when bits 4:2 ones
// - precision flag picks high or low ranges
// - low nine bits 111111100 mean void extent
// - bottom four bits zero give NaN
// - unlisted encodings have undefined results
// - more than 64 indices gives NaN
// - index bits outside 24..96 give NaN
// - indices read bit-reversed from the top
// - dual plane: second index one component
// - single plane: one index all components
// - channel selector sits below index bits
// - selector 0..3 maps red green blue alpha
// - dual plane indices alternate between planes
// - infill per plane from grid corners
// - infill weights are sixteenths
// - four-bit endpoint mode picks one of sixteen
// - class sets value count, class 3 dual six
// - modes 2,3,7,11,14,15 are high range
// - range code with precision sets composition
// - 3D grid dimensions span two to six
// - error colour is opaque magenta
module tbi_decoder (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// sampler side
	output logic             tex_done,
	output logic      [1:0]  tex_status,
	output logic      [6:0]  tex_wgt_red,
	output logic      [6:0]  tex_wgt_green,
	output logic      [6:0]  tex_wgt_blue,
	output logic      [6:0]  tex_wgt_alpha,
	output logic      [31:0] tex_color
);

	function automatic logic [31:0] tbi_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : tbi_merge

	// {max[4:0], trit, quint, bits[2:0]}; zero means unusable range
	function automatic logic [9:0] tbi_range(input logic prec, input logic [2:0] r);
		logic [9:0] v;
		v = 10'h000;
		unique case ({prec, r})
			4'h2:    v = {5'h01, 2'b00, 3'h1};
			4'h3:    v = {5'h02, 2'b10, 3'h0};
			4'h4:    v = {5'h03, 2'b00, 3'h2};
			4'h5:    v = {5'h04, 2'b01, 3'h0};
			4'h6:    v = {5'h05, 2'b10, 3'h1};
			4'h7:    v = {5'h07, 2'b00, 3'h3};
			4'hA:    v = {5'h09, 2'b01, 3'h1};
			4'hB:    v = {5'h0B, 2'b10, 3'h2};
			4'hC:    v = {5'h0F, 2'b00, 3'h4};
			4'hD:    v = {5'h13, 2'b01, 3'h2};
			4'hE:    v = {5'h17, 2'b10, 3'h3};
			4'hF:    v = {5'h1F, 2'b00, 3'h5};
			default: v = 10'h000;
		endcase
		return v;
	endfunction : tbi_range

	// grid position {int[3:0], frac[3:0]} of texel c in footprint b
	function automatic logic [7:0] tbi_infill(input logic [3:0] b, input logic [3:0] c,
		input logic [3:0] n);
		logic [17:0] ds;
		logic [17:0] gs;
		ds = 18'h00000;
		if (b > 4'h1)
			ds = (tbi_pkg::TBI_GRID_ONE + {15'h0000, b[3:1]}) / {14'h0000, 4'(b - 4'h1)};
		gs = ((ds * {14'h0000, c} * {14'h0000, 4'(n - 4'h1)}) + 18'h00020) >> 6;
		return gs[7:0];
	endfunction : tbi_infill

	// stored state
	logic [127:0]             blk_q;
	logic [11:0]              foot_q;
	logic [11:0]              coord_q;
	tbi_pkg::tbi_state_t      state_q;
	logic [2:0]               step_q;
	logic [12:0]              acc_q [2];

	// decode
	logic [10:0]              mode;
	logic [3:0]               d_n, d_m, d_q;
	logic                     d_dual, d_prec, d_void, d_resv;
	logic [2:0]               d_rng;
	logic [9:0]               rinfo;
	logic [7:0]               n_grid;
	logic [8:0]               n_idx;
	logic [11:0]              ibits;
	logic [1:0]               ccs;
	logic [3:0]               endpoint_mode_code;
	logic [3:0]               nvals;
	logic                     hdr;
	logic                     over_foot;
	tbi_pkg::tbi_result_t     res;

	logic [3:0]               dn_q, dm_q, dq_q, nvals_q, endpoint_mode_code_q;
	logic                     dual_q, prec_q, hdr_q, isq_q;
	logic [2:0]               rng_q;
	logic [9:0]               rinfo_q;
	logic [11:0]              ibits_q;
	logic [1:0]               ccs_q;
	tbi_pkg::tbi_result_t     res_q;

	always_comb
	begin
		mode   = blk_q[10:0];
		d_n    = 4'h0;
		d_m    = 4'h0;
		d_q    = 4'h0;
		d_dual = mode[10];
		d_prec = mode[9];
		d_rng  = {mode[1:0], mode[4]};
		d_void = 1'b0;
		d_resv = 1'b0;
		if (mode[8:0] == tbi_pkg::TBI_VOID_PAT)
			d_void = 1'b1;
		else if (mode[3:0] == 4'h0)
			d_resv = 1'b1;
		else if (mode[1:0] != 2'b00)
		begin
			d_n = {2'b00, mode[6:5]} + tbi_pkg::TBI_DIM_BASE;
			d_m = {2'b00, mode[8:7]} + tbi_pkg::TBI_DIM_BASE;
			d_q = {2'b00, mode[3:2]} + tbi_pkg::TBI_DIM_BASE;
		end
		else
		begin
			d_rng = {mode[3:2], mode[4]};
			unique case (mode[8:7])
				2'b00:
				begin
					d_n = tbi_pkg::TBI_DIM_FIXED;
					d_m = {2'b00, mode[10:9]} + tbi_pkg::TBI_DIM_BASE;
					d_q = {2'b00, mode[6:5]} + tbi_pkg::TBI_DIM_BASE;
				end
				2'b01:
				begin
					d_n = {2'b00, mode[6:5]} + tbi_pkg::TBI_DIM_BASE;
					d_m = tbi_pkg::TBI_DIM_FIXED;
					d_q = {2'b00, mode[10:9]} + tbi_pkg::TBI_DIM_BASE;
				end
				2'b10:
				begin
					d_n = {2'b00, mode[6:5]} + tbi_pkg::TBI_DIM_BASE;
					d_m = {2'b00, mode[10:9]} + tbi_pkg::TBI_DIM_BASE;
					d_q = tbi_pkg::TBI_DIM_FIXED;
				end
				2'b11:
				begin
					d_n = (mode[6:5] == 2'b00) ? tbi_pkg::TBI_DIM_FIXED : tbi_pkg::TBI_DIM_BASE;
					d_m = (mode[6:5] == 2'b01) ? tbi_pkg::TBI_DIM_FIXED : tbi_pkg::TBI_DIM_BASE;
					d_q = (mode[6:5] == 2'b10) ? tbi_pkg::TBI_DIM_FIXED : tbi_pkg::TBI_DIM_BASE;
					// non-void rest of the row is reserved
					d_resv = (mode[6:5] == 2'b11);
				end
			endcase
			// first three fixed-six rows carry no plane or precision flags
			if (mode[8:7] != 2'b11)
			begin
				d_dual = 1'b0;
				d_prec = 1'b0;
			end
		end
		rinfo  = tbi_range(d_prec, d_rng);
		n_grid = {4'h0, d_n} * {4'h0, d_m} * {4'h0, d_q};
		n_idx  = d_dual ? {n_grid, 1'b0} : {1'b0, n_grid};
		ibits  = (rinfo[4] ? (({3'h0, n_idx} * 12'h008) / 12'h005) : 12'h000)
			+ (rinfo[3] ? (({3'h0, n_idx} * 12'h007) / 12'h003) : 12'h000)
			+ ({3'h0, n_idx} * {9'h000, rinfo[2:0]});
		ccs    = 2'b00;
		if (ibits <= tbi_pkg::TBI_ISQ_MAX)
			ccs = 2'(blk_q >> 7'(tbi_pkg::TBI_ISQ_TOP - ibits));
		endpoint_mode_code = blk_q[tbi_pkg::TBI_ENDPOINT_MODE_LSB +: 4];
		nvals  = ((endpoint_mode_code[3:2] == 2'b11) && d_dual) ? 4'h6
			: ({1'b0, endpoint_mode_code[3:2], 1'b0} + 4'h2);
		hdr    = endpoint_mode_code inside {4'h2, 4'h3, 4'h7, 4'hB, 4'hE, 4'hF};
		over_foot = (d_n > foot_q[3:0]) || (d_m > foot_q[7:4]) || (d_q > foot_q[11:8]);
		if (d_void)
			res = tbi_pkg::TBI_RES_VOID;
		else if (d_resv || (rinfo == 10'h000))
			res = tbi_pkg::TBI_RES_NAN;
		else if (over_foot || (d_dual && (blk_q[tbi_pkg::TBI_PART_LSB +: 2] == 2'b11)))
			res = tbi_pkg::TBI_RES_ERROR;
		else if ((n_idx > tbi_pkg::TBI_IDX_MAX) || (ibits < tbi_pkg::TBI_ISQ_MIN)
			|| (ibits > tbi_pkg::TBI_ISQ_MAX))
			res = tbi_pkg::TBI_RES_NAN;
		else
			res = tbi_pkg::TBI_RES_NORMAL;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dn_q    <= 4'h0;
			dm_q    <= 4'h0;
			dq_q    <= 4'h0;
			dual_q  <= 1'b0;
			prec_q  <= 1'b0;
			rng_q   <= 3'h0;
			rinfo_q <= 10'h000;
			ibits_q <= 12'h000;
			ccs_q   <= 2'b00;
			endpoint_mode_code_q <= 4'h0;
			nvals_q <= 4'h0;
			hdr_q   <= 1'b0;
			isq_q   <= 1'b0;
			res_q   <= tbi_pkg::TBI_RES_NAN;
		end
		else
		begin
			dn_q    <= d_n;
			dm_q    <= d_m;
			dq_q    <= d_q;
			dual_q  <= d_dual;
			prec_q  <= d_prec;
			rng_q   <= d_rng;
			rinfo_q <= rinfo;
			ibits_q <= ibits;
			ccs_q   <= ccs;
			endpoint_mode_code_q <= endpoint_mode_code;
			nvals_q <= nvals;
			hdr_q   <= hdr;
			isq_q   <= rinfo[4] | rinfo[3];
			res_q   <= res;
		end
	end

	// apb decode
	logic        setup, wr_acc, busy;
	logic [31:0] rd_data;
	logic        hit;
	logic [31:0] wmerge;

	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign busy   = (state_q != tbi_pkg::TBI_IDLE);

	always_comb
	begin
		hit     = 1'b1;
		rd_data = 32'h00000000;
		wmerge  = 32'h00000000;
		unique case (paddr)
			tbi_pkg::TBI_ADDR_BLK0:   rd_data = blk_q[31:0];
			tbi_pkg::TBI_ADDR_BLK1:   rd_data = blk_q[63:32];
			tbi_pkg::TBI_ADDR_BLK2:   rd_data = blk_q[95:64];
			tbi_pkg::TBI_ADDR_BLK3:   rd_data = blk_q[127:96];
			tbi_pkg::TBI_ADDR_FOOT:   rd_data = {20'h00000, foot_q};
			tbi_pkg::TBI_ADDR_TEXEL:  rd_data = {20'h00000, coord_q};
			tbi_pkg::TBI_ADDR_STATUS: rd_data = {27'h0000000, isq_q, busy, 1'b0, res_q};
			tbi_pkg::TBI_ADDR_GRID:   rd_data = {4'h0, ibits_q[10:0], rng_q, prec_q, dual_q,
				dq_q, dm_q, dn_q};
			tbi_pkg::TBI_ADDR_ENDP:   rd_data = {19'h00000, ccs_q, hdr_q, nvals_q, 2'b00,
				endpoint_mode_code_q};
			tbi_pkg::TBI_ADDR_WEIGHT: rd_data = {16'h0000, 1'b0, tex_wgt_alpha, 1'b0,
				tex_wgt_red};
			tbi_pkg::TBI_ADDR_COMPW:  rd_data = {1'b0, tex_wgt_alpha, 1'b0, tex_wgt_blue,
				1'b0, tex_wgt_green, 1'b0, tex_wgt_red};
			tbi_pkg::TBI_ADDR_COLOR:  rd_data = tex_color;
			default:                  hit = 1'b0;
		endcase
		wmerge = tbi_merge(rd_data, pwdata, pstrb);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			if (setup)
			begin
				prdata  <= pwrite ? 32'h00000000 : rd_data;
				pslverr <= !hit;
			end
		end
	end

	// block and footprint frozen while a texel is in flight
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blk_q  <= 128'h0;
			foot_q <= tbi_pkg::TBI_FOOT_RST;
		end
		else if (wr_acc && !busy)
		begin
			unique case (paddr)
				tbi_pkg::TBI_ADDR_BLK0: blk_q[31:0]   <= wmerge;
				tbi_pkg::TBI_ADDR_BLK1: blk_q[63:32]  <= wmerge;
				tbi_pkg::TBI_ADDR_BLK2: blk_q[95:64]  <= wmerge;
				tbi_pkg::TBI_ADDR_BLK3: blk_q[127:96] <= wmerge;
				tbi_pkg::TBI_ADDR_FOOT: foot_q        <= wmerge[11:0];
				default:                foot_q        <= foot_q;
			endcase
		end
	end

	// texel walk
	logic [7:0]  inf_s, inf_t, inf_r;
	logic [3:0]  jr;
	logic        cx, cy, plane;
	logic [3:0]  xg, yg;
	logic [7:0]  gidx;
	logic [8:0]  seq_pos;
	logic [4:0]  raw;
	logic [6:0]  wscaled;
	logic [4:0]  cw, w11;
	logic [11:0] prod;
	logic        last;
	logic [6:0]  wfin [2];
	logic [6:0]  comp_w [4];

	assign inf_s = tbi_infill(foot_q[3:0], coord_q[3:0], dn_q);
	assign inf_t = tbi_infill(foot_q[7:4], coord_q[7:4], dm_q);
	assign inf_r = tbi_infill(foot_q[11:8], coord_q[11:8], dq_q);
	assign jr    = 4'((inf_r + 8'h08) >> 4);
	assign cx    = step_q[0];
	assign cy    = step_q[1];
	assign plane = step_q[2];
	assign xg    = (cx && (inf_s[7:4] < 4'(dn_q - 4'h1))) ? inf_s[7:4] + 4'h1 : inf_s[7:4];
	assign yg    = (cy && (inf_t[7:4] < 4'(dm_q - 4'h1))) ? inf_t[7:4] + 4'h1 : inf_t[7:4];
	assign gidx  = {4'h0, xg} + {4'h0, dn_q} * ({4'h0, yg} + {4'h0, dm_q} * {4'h0, jr});
	assign seq_pos = dual_q ? ({gidx, 1'b0} + {8'h00, plane}) : {1'b0, gidx};

	tbi_index_fetch u_fetch (
		.blk     (blk_q),
		.seq_pos (seq_pos),
		.width   (rinfo_q[2:0]),
		.value   (raw)
	);

	assign wscaled = (isq_q || (rinfo_q[9:5] == 5'h00)) ? 7'h00 :
		7'(({6'h00, raw} * 11'h040 + {7'h00, rinfo_q[9:6]}) / {6'h00, rinfo_q[9:5]});

	assign w11 = 5'((({1'b0, inf_s[3:0]} * {1'b0, inf_t[3:0]}) + 10'h008) >> 4);
	always_comb
	begin
		unique case ({cy, cx})
			2'b00: cw = tbi_pkg::TBI_FRAC_ONE - {1'b0, inf_s[3:0]} - {1'b0, inf_t[3:0]} + w11;
			2'b01: cw = {1'b0, inf_s[3:0]} - w11;
			2'b10: cw = {1'b0, inf_t[3:0]} - w11;
			2'b11: cw = w11;
		endcase
	end
	assign prod = {5'h00, wscaled} * {7'h00, cw};
	assign last = dual_q ? (step_q == 3'h7) : (step_q == 3'h3);
	assign wfin[0] = 7'((acc_q[0] + 13'h0008) >> 4);
	assign wfin[1] = 7'((acc_q[1] + 13'h0008) >> 4);

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++)
		begin : g_chan
			assign comp_w[ch] = (res_q != tbi_pkg::TBI_RES_NORMAL) ? 7'h00 :
				(dual_q && (ccs_q == 2'(ch))) ? wfin[1] : wfin[0];
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q  <= tbi_pkg::TBI_IDLE;
			step_q   <= 3'h0;
			coord_q  <= tbi_pkg::TBI_COORD_RST;
			acc_q[0] <= 13'h0000;
			acc_q[1] <= 13'h0000;
		end
		else
		begin
			unique case (state_q)
				tbi_pkg::TBI_IDLE:
				begin
					if (wr_acc && (paddr == tbi_pkg::TBI_ADDR_TEXEL))
					begin
						coord_q  <= wmerge[11:0];
						step_q   <= 3'h0;
						acc_q[0] <= 13'h0000;
						acc_q[1] <= 13'h0000;
						state_q  <= tbi_pkg::TBI_RUN;
					end
				end
				tbi_pkg::TBI_RUN:
				begin
					acc_q[plane] <= acc_q[plane] + {1'b0, prod};
					step_q       <= step_q + 3'h1;
					if (last)
						state_q <= tbi_pkg::TBI_FIN;
				end
				tbi_pkg::TBI_FIN:
					state_q <= tbi_pkg::TBI_IDLE;
				default:
					state_q <= tbi_pkg::TBI_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tex_done      <= 1'b0;
			tex_status    <= tbi_pkg::TBI_RES_NAN;
			tex_wgt_red   <= 7'h00;
			tex_wgt_green <= 7'h00;
			tex_wgt_blue  <= 7'h00;
			tex_wgt_alpha <= 7'h00;
			tex_color     <= 32'h00000000;
		end
		else
		begin
			tex_done <= (state_q == tbi_pkg::TBI_FIN);
			if (state_q == tbi_pkg::TBI_FIN)
			begin
				tex_status    <= res_q;
				tex_wgt_red   <= comp_w[0];
				tex_wgt_green <= comp_w[1];
				tex_wgt_blue  <= comp_w[2];
				tex_wgt_alpha <= comp_w[3];
				unique case (res_q)
					tbi_pkg::TBI_RES_ERROR:  tex_color <= tbi_pkg::TBI_COLOR_ERR;
					tbi_pkg::TBI_RES_NAN:    tex_color <= tbi_pkg::TBI_COLOR_NAN;
					tbi_pkg::TBI_RES_VOID:   tex_color <= {blk_q[79:72], blk_q[95:88],
						blk_q[111:104], blk_q[127:120]};
					tbi_pkg::TBI_RES_NORMAL: tex_color <= 32'h00000000;
				endcase
			end
		end
	end

endmodule : tbi_decoder

/* File: tbi_pkg.sv */
/*
 * Shared constants and types for the texture block index-mode decoder:
 * APB register offsets, reset values, decode patterns and limits.
 * Assumes a 32-bit APB with byte addresses on an 8-bit paddr.
 */
package tbi_pkg;

	// register byte offsets
	localparam logic [7:0] TBI_ADDR_BLK0   = 8'h00;
	localparam logic [7:0] TBI_ADDR_BLK1   = 8'h04;
	localparam logic [7:0] TBI_ADDR_BLK2   = 8'h08;
	localparam logic [7:0] TBI_ADDR_BLK3   = 8'h0C;
	localparam logic [7:0] TBI_ADDR_FOOT   = 8'h10;
	localparam logic [7:0] TBI_ADDR_TEXEL  = 8'h14;
	localparam logic [7:0] TBI_ADDR_STATUS = 8'h18;
	localparam logic [7:0] TBI_ADDR_GRID   = 8'h1C;
	localparam logic [7:0] TBI_ADDR_ENDP   = 8'h20;
	localparam logic [7:0] TBI_ADDR_WEIGHT = 8'h24;
	localparam logic [7:0] TBI_ADDR_COMPW  = 8'h28;
	localparam logic [7:0] TBI_ADDR_COLOR  = 8'h2C;

	// reset values
	localparam logic [11:0] TBI_FOOT_RST  = 12'h666;
	localparam logic [11:0] TBI_COORD_RST = 12'h000;

	// block field positions
	localparam int TBI_PART_LSB          = 11;
	localparam int TBI_ENDPOINT_MODE_LSB = 13;

	// decode patterns and limits
	localparam logic [8:0]  TBI_VOID_PAT  = 9'h1FC;
	localparam logic [8:0]  TBI_IDX_MAX   = 9'h040;
	localparam logic [11:0] TBI_ISQ_MIN   = 12'h018;
	localparam logic [11:0] TBI_ISQ_MAX   = 12'h060;
	localparam logic [11:0] TBI_ISQ_TOP   = 12'h07E;
	localparam logic [17:0] TBI_GRID_ONE  = 18'h00400;
	localparam logic [4:0]  TBI_FRAC_ONE  = 5'h10;
	localparam logic [3:0]  TBI_DIM_FIXED = 4'h6;
	localparam logic [3:0]  TBI_DIM_BASE  = 4'h2;

	// result colours
	localparam logic [31:0] TBI_COLOR_ERR = 32'hFF00FFFF;
	localparam logic [31:0] TBI_COLOR_NAN = 32'hFFFFFFFF;

	typedef enum logic [1:0] {
		TBI_RES_NORMAL,
		TBI_RES_VOID,
		TBI_RES_ERROR,
		TBI_RES_NAN
	} tbi_result_t;

	typedef enum logic [1:0] {
		TBI_IDLE,
		TBI_RUN,
		TBI_FIN
	} tbi_state_t;

endpackage : tbi_pkg

/* File: tbi_index_fetch.sv */
/*
 * Pulls one index value out of the stored 128-bit block.
 * Assumes the caller gives the sequence position and bits per index.
 */
`timescale 1ns/1ps

module tbi_index_fetch (
	// block and selection
	input  wire logic [127:0] blk,
	input  wire logic [8:0]   seq_pos,
	input  wire logic [2:0]   width,
	// fetched value
	output logic      [4:0]   value
);

	logic [11:0] start;

	assign start = {3'h0, seq_pos} * {9'h000, width};

	genvar k;
	generate
		for (k = 0; k < 5; k++)
		begin : g_bit
			logic [11:0] pos;
			assign pos = start + 12'(k);
			assign value[k] = ((3'(k) < width) && (pos < 12'h080)) ?
				blk[7'(12'h07F - pos)] : 1'b0;
		end
	endgenerate

endmodule : tbi_index_fetch

/* File: tbi_decoder_sva.sv */
/*
 * Port checker for tbi_decoder: result pulse, status, colours and weights.
 * Assumes the bind below and an APB master that never starts a texel while busy.
 */
`timescale 1ns/1ps

module tbi_decoder_sva (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	// sampler side
	input wire logic        tex_done,
	input wire logic [1:0]  tex_status,
	input wire logic [6:0]  tex_wgt_red,
	input wire logic [6:0]  tex_wgt_green,
	input wire logic [6:0]  tex_wgt_blue,
	input wire logic [6:0]  tex_wgt_alpha,
	input wire logic [31:0] tex_color
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic go;
	logic nrm;
	assign go  = psel && penable && pwrite && pready && paddr == tbi_pkg::TBI_ADDR_TEXEL;
	assign nrm = tex_done && tex_status == tbi_pkg::TBI_RES_NORMAL;

	property p_ready; $past(presetn) |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low after reset");
	property p_pulse; tex_done |=> !tex_done; endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
	property p_hold; !tex_done |-> $stable(tex_status); endproperty
	a_hold: assert property (p_hold) else $error("status moved without done");
	property p_lat; go |-> ##[5:10] tex_done; endproperty
	a_lat: assert property (p_lat) else $error("texel result late");
	property p_err;
		tex_done && tex_status == tbi_pkg::TBI_RES_ERROR |-> tex_color == tbi_pkg::TBI_COLOR_ERR;
	endproperty
	a_err: assert property (p_err) else $error("error colour wrong");
	property p_nan;
		tex_done && tex_status == tbi_pkg::TBI_RES_NAN |-> tex_color == tbi_pkg::TBI_COLOR_NAN;
	endproperty
	a_nan: assert property (p_nan) else $error("nan colour wrong");
	property p_zero;
		tex_done && !nrm |-> (tex_wgt_red | tex_wgt_green | tex_wgt_blue | tex_wgt_alpha) == 7'h00;
	endproperty
	a_zero: assert property (p_zero) else $error("weights set on bad block");
	property p_max;
		tex_done |-> tex_wgt_red <= 7'h40 && tex_wgt_green <= 7'h40
			&& tex_wgt_blue <= 7'h40 && tex_wgt_alpha <= 7'h40;
	endproperty
	a_max: assert property (p_max) else $error("weight above 64");
	// three components always share the first plane
	property p_plane;
		nrm |-> (tex_wgt_red == tex_wgt_green && tex_wgt_green == tex_wgt_blue)
			|| (tex_wgt_red == tex_wgt_green && tex_wgt_green == tex_wgt_alpha)
			|| (tex_wgt_red == tex_wgt_blue && tex_wgt_blue == tex_wgt_alpha)
			|| (tex_wgt_green == tex_wgt_blue && tex_wgt_blue == tex_wgt_alpha);
	endproperty
	a_plane: assert property (p_plane) else $error("plane weights split wrongly");

	c_void: cover property (tex_done && tex_status == tbi_pkg::TBI_RES_VOID);
	c_err: cover property (tex_done && tex_status == tbi_pkg::TBI_RES_ERROR);
	c_dual: cover property (nrm && tex_wgt_red != tex_wgt_alpha);
endmodule : tbi_decoder_sva

bind tbi_decoder tbi_decoder_sva u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .tex_done(tex_done), .tex_status(tex_status),
	.tex_wgt_red(tex_wgt_red), .tex_wgt_green(tex_wgt_green), .tex_wgt_blue(tex_wgt_blue),
	.tex_wgt_alpha(tex_wgt_alpha), .tex_color(tex_color)
);

/* File: tbi_sampler_model.sv */
/*
 * Sampler-side model: latches each texel result and counts results.
 * Assumes results are valid only in the cycle that tex_done is high.
 */
`timescale 1ns/1ps

module tbi_sampler_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// decoder results
	input  wire logic        tex_done,
	input  wire logic [1:0]  tex_status,
	input  wire logic [6:0]  tex_wgt_red,
	input  wire logic [6:0]  tex_wgt_green,
	input  wire logic [6:0]  tex_wgt_blue,
	input  wire logic [6:0]  tex_wgt_alpha,
	input  wire logic [31:0] tex_color,
	// captured result
	output logic      [61:0] cap_q,
	output logic      [7:0]  done_cnt_q
);
	// outputs are only trusted in the done cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap_q      <= '0;
			done_cnt_q <= 8'h00;
		end
		else if (tex_done)
		begin
			cap_q      <= {tex_status, tex_wgt_red, tex_wgt_green, tex_wgt_blue, tex_wgt_alpha,
				tex_color};
			done_cnt_q <= done_cnt_q + 8'h01;
		end
	end
endmodule : tbi_sampler_model

/* File: tbi_decoder_tb_top.sv */
/*
 * Testbench for tbi_decoder: APB tasks, result table, modes, texel weights.
 * Assumes the bound checker and the sampler model that latches results.
 */
`timescale 1ns/1ps
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin bad_count++; \
	$display("BAD t=%0t got %h exp %h", $time, (act), (exp)); end end

module tbi_decoder_tb_top;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, tex_color, rq;
	logic        pready, pslverr, tex_done, re;
	logic [1:0]  tex_status;
	logic [6:0]  tex_wgt_red, tex_wgt_green, tex_wgt_blue, tex_wgt_alpha;
	logic [61:0] cap;
	logic [7:0]  done_cnt;
	int          bad_count = 0;
	int          compares  = 0;
	int          cyc       = 0;
	localparam logic [12:0] ST_BLK [13] = '{13'h00D3, 13'h0028, 13'h0028, 13'h01FC, 13'h07FC,
		13'h01E4, 13'h00F0, 13'h05F3, 13'h0001, 13'h014A, 13'h1CD3, 13'h04D3, 13'h0153};
	localparam logic [1:0]  ST_EXP [13] = '{0, 0, 2, 1, 1, 3, 3, 3, 3, 3, 2, 3, 0};
	localparam logic [12:0] GR_BLK [7]  = '{13'h00D3, 13'h0028, 13'h02D3, 13'h0413, 13'h0088,
		13'h05BC, 13'h0334};
	localparam logic [31:0] GR_EXP [7]  = '{32'h0091C234, 32'h00910326, 32'h00F1E234,
		32'h0061D222, 32'h00610262, 32'h0121D262, 32'h00ACC633};

	always #50 pclk = ~pclk;

	tbi_decoder u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tex_done(tex_done), .tex_status(tex_status),
		.tex_wgt_red(tex_wgt_red), .tex_wgt_green(tex_wgt_green), .tex_wgt_blue(tex_wgt_blue),
		.tex_wgt_alpha(tex_wgt_alpha), .tex_color(tex_color)
	);

	tbi_sampler_model u_model (
		.pclk(pclk), .presetn(presetn), .tex_done(tex_done), .tex_status(tex_status),
		.tex_wgt_red(tex_wgt_red), .tex_wgt_green(tex_wgt_green), .tex_wgt_blue(tex_wgt_blue),
		.tex_wgt_alpha(tex_wgt_alpha), .tex_color(tex_color), .cap_q(cap), .done_cnt_q(done_cnt)
	);

	task automatic tally_and_finish;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// trailing idle edge keeps psel from being driven twice in one step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rq = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	task automatic load(input logic [127:0] b, input logic [11:0] f);
		for (int i = 0; i < 4; i++)
			xfer(1'b1, 8'(4 * i), b[32 * i +: 32]);
		xfer(1'b1, tbi_pkg::TBI_ADDR_FOOT, {20'h0, f});
	endtask : load

	task automatic tex(input logic [11:0] c);
		logic [7:0] k;
		int         n;
		k = done_cnt;
		n = 0;
		xfer(1'b1, tbi_pkg::TBI_ADDR_TEXEL, {20'h0, c});
		while (done_cnt === k && n < 30)
		begin
			@(posedge pclk);
			n++;
		end
		`CHK(done_cnt, k + 8'h01)
	endtask : tex

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	initial
	begin
		logic [127:0] b;
		logic [31:0]  col;
		logic [27:0]  ev;
		logic [6:0]   w1, w2;
		int           v;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, tbi_pkg::TBI_ADDR_FOOT, 32'h0);
		`CHK(rq, {20'h0, tbi_pkg::TBI_FOOT_RST})
		xfer(1'b0, tbi_pkg::TBI_ADDR_STATUS, 32'h0);
		`CHK(rq[1:0], 2'h3)
		xfer(1'b0, 8'h40, 32'h0);
		`CHK({re, rq}, 33'h100000000)
		for (int i = 0; i < 13; i++)
		begin
			load({115'h0, ST_BLK[i]}, (i == 2) ? 12'h665 : 12'h666);
			xfer(1'b0, tbi_pkg::TBI_ADDR_STATUS, 32'h0);
			`CHK(rq[1:0], ST_EXP[i])
			tex(12'h000);
			col = (ST_EXP[i] == 2'h2) ? tbi_pkg::TBI_COLOR_ERR : 32'h0;
			col = (ST_EXP[i] == 2'h3) ? tbi_pkg::TBI_COLOR_NAN : col;
			`CHK(cap[61:60], ST_EXP[i])
			`CHK(cap[31:0], col)
		end
		for (int i = 0; i < 7; i++)
		begin
			load({115'h0, GR_BLK[i]}, 12'h666);
			xfer(1'b0, tbi_pkg::TBI_ADDR_GRID, 32'h0);
			`CHK(rq, GR_EXP[i])
		end
		for (int i = 0; i < 32; i++)
		begin
			v = (i % 16 >= 12 && i >= 16) ? 6 : 2 * (i % 16 / 4 + 1);
			xfer(1'b1, tbi_pkg::TBI_ADDR_BLK0, {15'h0, 4'(i), (i >= 16) ? 13'h0413 : 13'h00D3});
			xfer(1'b0, tbi_pkg::TBI_ADDR_ENDP, 32'h0);
			`CHK({rq[9:6], rq[3:0]}, {4'(v), 4'(i)})
			`CHK(rq[10], ((i % 16) inside {2, 3, 7, 11, 14, 15}))
		end
		// index k holds value k, read from the top down
		b = {117'h0, 11'h013};
		for (int k = 0; k < 8; k++)
			for (int j = 0; j < 3; j++)
				b[127 - 3 * k - j] = k[j];
		load(b, 12'h222);
		for (int k = 0; k < 8; k++)
		begin
			tex({4'(k / 4), 4'(k / 2 % 2), 4'(k % 2)});
			w1 = 7'((k * 64 + 3) / 7);
			`CHK(cap[59:32], {4{w1}})
		end
		b = {117'h0, 11'h013};
		for (int k = 1; k < 8; k += 2)
			for (int j = 0; j < 3; j++)
				b[127 - 3 * k - j] = 1'b1;
		load(b, 12'h223);
		for (int s = 0; s < 3; s++)
		begin
			tex(12'(s));
			`CHK(cap[59:32], {4{7'(32 * s)}})
		end
		// plane two carries the mirrored values
		b = {117'h0, 11'h413};
		for (int p = 0; p < 16; p++)
		begin
			v = p[0] ? 7 - p / 2 : p / 2;
			for (int j = 0; j < 3; j++)
				b[127 - 3 * p - j] = v[j];
		end
		for (int c = 0; c < 4; c++)
		begin
			b[79:78] = 2'(c);
			load(b, 12'h222);
			tex({4'(c / 2), 4'(c % 2), 4'h1});
			w1 = 7'(((2 * c + 1) * 64 + 3) / 7);
			w2 = 7'(((6 - 2 * c) * 64 + 3) / 7);
			for (int h = 0; h < 4; h++)
				ev[27 - 7 * h -: 7] = (h == c) ? w2 : w1;
			`CHK(cap[59:32], ev)
		end
		tally_and_finish();
	end
endmodule : tbi_decoder_tb_top
